// [rtl/gem_mac.sv]
// Ethernet MAC core: AHB-Lite registers, transmit, receive, flow control and SMI master.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - Gigabit is full duplex; 10/100 either duplex.
// - Half duplex defers to carrier, handles collisions.
// - Full duplex uses pause flow control.
// - Retry-disable bit aborts a collided frame.
// - Each frame chooses appended checksum or none.
// - Short frames padded; receive padding stripped.
// - Inter-packet gap always follows each frame.
// - Collisions matter only in half duplex.
// - Valid pause frame holds off data transmission.
// - Core builds and sends its own pause frames.
// - Byte lanes at gigabit, nibble lanes otherwise.
// - Registers give indirect PHY management access.
// - Transmit and receive paths run independently.
// - Collision stops data and sends jam.
// - Backoff counted in 512-bit slot times.
// - Backoff exponent capped by software limit field.
// - Collision pulses rewind; FIFO restarts frame.
// - Done or abort pulses release; FIFO advances.
// - Pause sent on request or by watermarks.
// - Pause quanta are 512 bits, 16-bit count.
// - Received pause waits for current frame end.
// - Flow-on sends programmed time; off sends zero.
// - Re-arm only after low then high crossing.
module gem_mac import gem_pkg::*; #(
	parameter logic [47:0] STATION_ADDR = 48'h02_00_00_00_00_01
) (
	// Clock and reset.
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	// AHB-Lite slave.
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// Transmit side of the FIFO controller.
	input  wire gem_tx_s     i_tx,
	input  wire logic        i_tx_valid,
	output logic             o_tx_ready,
	output logic             o_frame_rewind,
	output logic             o_frame_release,
	// Receive side of the FIFO controller.
	output gem_rx_s          o_rx,
	input  wire logic        i_flow_on,
	input  wire logic        i_flow_off,
	// PHY data lanes.
	output logic      [7:0]  o_phy_txd,
	output logic             o_phy_tx_en,
	output logic             o_phy_gmii_sel,
	input  wire logic [7:0]  i_phy_rxd,
	input  wire logic        i_phy_rx_dv,
	input  wire logic        i_phy_rx_er,
	input  wire logic        i_phy_col,
	input  wire logic        i_phy_crs,
	// Serial management bus.
	output logic             o_mdc,
	output logic             o_mdio_out,
	output logic             o_mdio_oe,
	input  wire logic        i_mdio_in
);
	logic [12:0] pin_s1_ff, pin_s2_ff;
	logic [7:0]  rxd_s;
	logic        rxdv_s, rxer_s, col_s, crs_s, mdio_s;
	logic [3:0]  backoff_limit_field_ff;
	logic [5:0]  maccr_ff;
	logic [19:0] flow_ff;
	logic        fdx, half, gmii;
	logic [4:0]  div_ff;
	logic        step, nib_ff, byte_step;
	gem_tx_state_e tst_ff;
	logic [15:0] cnt_ff, slots_ff, ptime_ff, pause_cnt_ff, target;
	logic [7:0]  sub_ff, cur_byte;
	logic [4:0]  att_ff;
	logic [31:0] crc_ff, crc_nxt;
	logic        src_pause_ff, fcs_ff, late_ff, emit, last_data, col_hit, start_data;
	logic        pend_on_ff, pend_zero_ff, armed_ff, take_pause, force_wr;
	logic [15:0] lfsr_ff;
	logic [5:0]  qsub_ff;
	logic [3:0]  kexp;
	gem_rx_state_e rst_ff;
	logic        rnib_ff, rbyte_vld, rx_end, mc_ok_ff, uc_ok_ff, ctl_ok_ff, rerr_ff;
	logic [3:0]  rlo_ff;
	logic [7:0]  rbyte;
	logic [15:0] rcnt_ff, len_ff, rptime_ff, out_idx;
	logic [31:0] rcrc_ff, dly_ff;
	logic        is_pause, crc_ok;
	logic        wpend_ff;
	logic [7:0]  waddr_ff;
	logic [31:0] rd_val;
	logic [11:0] acc_ff;
	logic [15:0] smi_data_ff;
	logic [63:0] sh_ff;
	logic [5:0]  bit_ff;
	logic [4:0]  mdiv_ff;
	logic        smi_busy_ff;

	// Every pin input passes two flip-flops; nothing reads the first stage.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_s1_ff <= 13'h0000;
			pin_s2_ff <= 13'h0000;
		end else begin
			pin_s1_ff <= {i_phy_rxd, i_phy_rx_dv, i_phy_rx_er, i_phy_col, i_phy_crs, i_mdio_in};
			pin_s2_ff <= pin_s1_ff;
		end
	end
	assign {rxd_s, rxdv_s, rxer_s, col_s, crs_s, mdio_s} = pin_s2_ff;

	// Mode decode; gigabit never runs half duplex.
	assign fdx  = maccr_ff[CR_FDX];
	assign gmii = maccr_ff[CR_SPD+:2] == SPD_1000;
	assign half = !fdx && !gmii;

	// Lane step divider: byte per step on GMII, nibble per step on MII.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_ff <= 5'h00;
			nib_ff <= 1'b0;
		end else if (step) begin
			div_ff <= gmii ? 5'h00 : (maccr_ff[CR_SPD+:2] == SPD_100) ?
				5'(NIB_CYC_100 - 1) : 5'(NIB_CYC_10 - 1);
			nib_ff <= gmii ? 1'b0 : !nib_ff;
		end else begin
			div_ff <= div_ff - 5'h01;
		end
	end
	assign step      = div_ff == 5'h00;
	assign byte_step = step && (gmii || nib_ff);

	// Transmit byte source and control decode.
	always_comb begin
		cur_byte = 8'h00;
		case (tst_ff)
			TX_PRE:  cur_byte = (sub_ff < 8'(PRE_BYTES - 1)) ? PRE_BYTE : SFD_BYTE;
			TX_DATA: cur_byte = src_pause_ff ? gem_pause_byte(cnt_ff, ptime_ff, STATION_ADDR) :
				i_tx.data;
			TX_FCS:  cur_byte = 8'(~crc_ff >> {sub_ff[1:0], 3'b000});
			TX_JAM:  cur_byte = JAM_BYTE;
			default: cur_byte = 8'h00;
		endcase
	end
	assign emit       = tst_ff inside {TX_PRE, TX_DATA, TX_PAD, TX_FCS, TX_JAM};
	assign last_data  = src_pause_ff ? (cnt_ff == 16'(PAUSE_LEN - 1)) : i_tx.last;
	assign o_tx_ready = tst_ff == TX_DATA && !src_pause_ff && byte_step;
	assign col_hit    = half && col_s && tst_ff inside {TX_PRE, TX_DATA, TX_PAD, TX_FCS};
	assign target     = fcs_ff ? 16'(MIN_FRAME) : 16'(MIN_NOFCS);
	assign crc_nxt    = gem_crc_byte(crc_ff, cur_byte);
	assign take_pause = tst_ff == TX_IDLE && byte_step && fdx && (pend_on_ff || pend_zero_ff);
	// Data frames wait out pause, and in half duplex also wait for a quiet carrier.
	assign start_data = i_tx_valid && maccr_ff[CR_TXEN] && pause_cnt_ff == 16'h0000 &&
		!(half && crs_s);
	assign kexp = (att_ff + 5'h01 < {1'b0, backoff_limit_field_ff}) ? 4'(att_ff + 5'h01) : backoff_limit_field_ff;

	// Transmit state machine; a pause frame reuses the data path with an internal source.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tst_ff          <= TX_IDLE;
			cnt_ff          <= 16'h0000;
			sub_ff          <= 8'h00;
			slots_ff        <= 16'h0000;
			att_ff          <= 5'h00;
			crc_ff          <= CRC_INIT;
			src_pause_ff    <= 1'b0;
			fcs_ff          <= 1'b1;
			late_ff         <= 1'b0;
			ptime_ff        <= 16'h0000;
			o_frame_rewind  <= 1'b0;
			o_frame_release <= 1'b0;
		end else begin
			o_frame_rewind  <= 1'b0;
			o_frame_release <= 1'b0;
			if (byte_step) begin
				if (col_hit) begin
					tst_ff  <= TX_JAM;
					sub_ff  <= 8'h00;
					late_ff <= (cnt_ff + 16'(PRE_BYTES)) >= 16'(SLOT_BYTES);
				end else begin
					case (tst_ff)
						TX_IDLE: begin
							if (take_pause || start_data) begin
								src_pause_ff <= take_pause;
								ptime_ff     <= pend_on_ff ? flow_ff[15:0] : 16'h0000;
								fcs_ff       <= take_pause ? 1'b1 : i_tx.fcs_en;
								tst_ff       <= TX_PRE;
								sub_ff       <= 8'h00;
								cnt_ff       <= 16'h0000;
								crc_ff       <= CRC_INIT;
							end
						end
						TX_PRE: begin
							sub_ff <= sub_ff + 8'h01;
							if (sub_ff == 8'(PRE_BYTES - 1)) begin
								tst_ff <= TX_DATA;
							end
						end
						TX_DATA, TX_PAD: begin
							crc_ff <= crc_nxt;
							cnt_ff <= cnt_ff + 16'h0001;
							sub_ff <= 8'h00;
							if (tst_ff == TX_PAD || last_data) begin
								if (cnt_ff + 16'h0001 < target) begin
									tst_ff <= TX_PAD;
								end else if (fcs_ff) begin
									tst_ff <= TX_FCS;
								end else begin
									tst_ff          <= TX_IPG;
									att_ff          <= 5'h00;
									o_frame_release <= !src_pause_ff;
								end
							end
						end
						TX_FCS: begin
							sub_ff <= sub_ff + 8'h01;
							if (sub_ff == 8'(FCS_BYTES - 1)) begin
								tst_ff          <= TX_IPG;
								sub_ff          <= 8'h00;
								att_ff          <= 5'h00;
								o_frame_release <= !src_pause_ff;
							end
						end
						TX_JAM: begin
							sub_ff <= sub_ff + 8'h01;
							if (sub_ff == 8'(JAM_BYTES - 1)) begin
								sub_ff <= 8'h00;
								cnt_ff <= 16'h0000;
								if (maccr_ff[CR_NORETRY] || late_ff ||
										att_ff == 5'(MAX_ATTEMPTS - 1)) begin
									tst_ff          <= TX_IPG;
									att_ff          <= 5'h00;
									o_frame_release <= !src_pause_ff;
								end else begin
									tst_ff         <= TX_BOFF;
									att_ff         <= att_ff + 5'h01;
									slots_ff       <= lfsr_ff & 16'((17'h00001 << kexp) - 17'h1);
									o_frame_rewind <= !src_pause_ff;
								end
							end
						end
						TX_BOFF: begin
							if (slots_ff == 16'h0000) begin
								tst_ff <= TX_IPG;
							end else if (cnt_ff == 16'(SLOT_BYTES - 1)) begin
								cnt_ff   <= 16'h0000;
								slots_ff <= slots_ff - 16'h0001;
							end else begin
								cnt_ff <= cnt_ff + 16'h0001;
							end
						end
						TX_IPG: begin
							sub_ff <= sub_ff + 8'h01;
							if (sub_ff == 8'(IPG_BYTES - 1)) begin
								tst_ff <= TX_IDLE;
							end
						end
						default: tst_ff <= TX_IDLE;
					endcase
				end
			end
		end
	end

	// Lane output register: whole byte on GMII, low nibble then high nibble on MII.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_phy_txd   <= 8'h00;
			o_phy_tx_en <= 1'b0;
		end else if (step) begin
			o_phy_txd   <= gmii ? cur_byte : {4'h0, nib_ff ? cur_byte[7:4] : cur_byte[3:0]};
			o_phy_tx_en <= emit;
		end
	end
	assign o_phy_gmii_sel = gmii;

	// Pause requests: a new request in the cycle of its take is kept, not lost.
	assign force_wr = wpend_ff && waddr_ff == REG_FLOW && i_hwdata[FLOW_FORCE];
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend_on_ff   <= 1'b0;
			pend_zero_ff <= 1'b0;
			armed_ff     <= 1'b1;
		end else begin
			if (force_wr || (i_flow_on && armed_ff && flow_ff[FLOW_AUTO] && fdx)) begin
				pend_on_ff <= 1'b1;
			end else if (take_pause && pend_on_ff) begin
				pend_on_ff <= 1'b0;
			end
			if (i_flow_off && !armed_ff && flow_ff[FLOW_AUTO] && fdx) begin
				pend_zero_ff <= 1'b1;
			end else if (take_pause && !pend_on_ff) begin
				pend_zero_ff <= 1'b0;
			end
			if (i_flow_on && armed_ff && flow_ff[FLOW_AUTO] && fdx) begin
				armed_ff <= 1'b0;
			end else if (i_flow_off && flow_ff[FLOW_AUTO]) begin
				armed_ff <= 1'b1;
			end
		end
	end

	// Backoff randomness from a free-running LFSR.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lfsr_ff <= 16'hace1;
		end else begin
			lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
		end
	end

	// Pause hold-off: quanta of 64 byte times; a new pause replaces the old count.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pause_cnt_ff <= 16'h0000;
			qsub_ff      <= 6'h00;
		end else if (rx_end && is_pause && crc_ok && flow_ff[FLOW_RXEN] && fdx) begin
			pause_cnt_ff <= rptime_ff;
			qsub_ff      <= 6'h00;
		end else if (byte_step && pause_cnt_ff != 16'h0000) begin
			qsub_ff <= qsub_ff + 6'h01;
			if (qsub_ff == 6'(SLOT_BYTES - 1)) begin
				pause_cnt_ff <= pause_cnt_ff - 16'h0001;
			end
		end
	end

	// Receive lane assembly, independent of the transmit path.
	assign rbyte_vld = step && rxdv_s && (gmii || rnib_ff);
	assign rbyte     = gmii ? rxd_s : {rxd_s[3:0], rlo_ff};
	assign rx_end    = step && !rxdv_s && rst_ff == RX_BODY;
	assign crc_ok    = rcrc_ff == CRC_RESIDUE;
	assign is_pause  = ctl_ok_ff && (mc_ok_ff || uc_ok_ff) && rcnt_ff >= 16'(PAUSE_LEN);
	assign out_idx   = rcnt_ff - 16'(FCS_BYTES);
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rnib_ff <= 1'b0;
			rlo_ff  <= 4'h0;
		end else if (step) begin
			rnib_ff <= rxdv_s && !gmii && !rnib_ff;
			rlo_ff  <= rxd_s[3:0];
		end
	end

	// Receive frame: strip preamble and checksum, drop pad, decode pause frames.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_ff    <= RX_IDLE;
			rcnt_ff   <= 16'h0000;
			rcrc_ff   <= CRC_INIT;
			dly_ff    <= 32'h00000000;
			len_ff    <= 16'hffff;
			rptime_ff <= 16'h0000;
			mc_ok_ff  <= 1'b0;
			uc_ok_ff  <= 1'b0;
			ctl_ok_ff <= 1'b0;
			rerr_ff   <= 1'b0;
			o_rx      <= '0;
		end else begin
			o_rx.vld <= 1'b0;
			o_rx.eof <= 1'b0;
			if (rx_end) begin
				rst_ff   <= RX_IDLE;
				o_rx.eof <= 1'b1;
				o_rx.ctl <= is_pause;
				o_rx.err <= rerr_ff || !crc_ok || rcnt_ff < 16'(MIN_FRAME + FCS_BYTES) ||
					(is_pause && !flow_ff[FLOW_FWD]);
			end else if (rst_ff == RX_IDLE) begin
				if (rbyte_vld && rbyte == SFD_BYTE && maccr_ff[CR_RXEN]) begin
					rst_ff    <= RX_BODY;
					rcnt_ff   <= 16'h0000;
					rcrc_ff   <= CRC_INIT;
					len_ff    <= 16'hffff;
					mc_ok_ff  <= 1'b1;
					uc_ok_ff  <= 1'b1;
					ctl_ok_ff <= 1'b1;
					rerr_ff   <= 1'b0;
				end
			end else if (rbyte_vld) begin
				rcrc_ff <= gem_crc_byte(rcrc_ff, rbyte);
				rcnt_ff <= rcnt_ff + 16'h0001;
				dly_ff  <= {dly_ff[23:0], rbyte};
				rerr_ff <= rerr_ff || rxer_s;
				if (rcnt_ff < 16'd6) begin
					mc_ok_ff <= mc_ok_ff && rbyte == gem_pause_byte(rcnt_ff, 16'h0000, STATION_ADDR);
					uc_ok_ff <= uc_ok_ff &&
						rbyte == gem_pause_byte(rcnt_ff + 16'd6, 16'h0000, STATION_ADDR);
				end
				if (rcnt_ff >= 16'd12 && rcnt_ff <= 16'd15) begin
					ctl_ok_ff <= ctl_ok_ff &&
						rbyte == gem_pause_byte(rcnt_ff, 16'h0000, STATION_ADDR);
				end
				if (rcnt_ff == 16'd12) begin
					len_ff <= {rbyte, 8'h00};
				end else if (rcnt_ff == 16'd13) begin
					len_ff <= {len_ff[15:8], rbyte};
				end
				if (rcnt_ff == 16'd16) begin
					rptime_ff <= {rbyte, 8'h00};
				end else if (rcnt_ff == 16'd17) begin
					rptime_ff <= {rptime_ff[15:8], rbyte};
				end
				// Four bytes of delay hold back the checksum; pad beyond the length is dropped.
				if (rcnt_ff >= 16'(FCS_BYTES) && !(len_ff < 16'(MIN_PAYLOAD) &&
						out_idx >= 16'(HDR_BYTES) + len_ff)) begin
					o_rx.vld  <= 1'b1;
					o_rx.data <= dly_ff[31:24];
				end
			end
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY, unmapped words read zero.
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	always_comb begin
		rd_val = 32'h00000000;
		case (i_haddr[7:0])
			REG_HWCFG:   rd_val = {28'h0000000, backoff_limit_field_ff};
			REG_MACCR:   rd_val = {26'h0000000, maccr_ff};
			REG_FLOW:    rd_val = {12'h000, flow_ff[19], 1'b0, flow_ff[17:0]} |
				(32'(pend_on_ff) << FLOW_FORCE);
			REG_SMIACC:  rd_val = {20'h00000, smi_busy_ff, acc_ff[10:0]};
			REG_SMIDATA: rd_val = {16'h0000, smi_data_ff};
			REG_STAT:    rd_val = {7'h00, att_ff, 2'h0, tst_ff != TX_IDLE,
				pause_cnt_ff != 16'h0000, pause_cnt_ff};
			default:     rd_val = 32'h00000000;
		endcase
	end
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wpend_ff <= 1'b0;
			waddr_ff <= 8'h00;
			o_hrdata <= 32'h00000000;
		end else begin
			wpend_ff <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
			waddr_ff <= i_haddr[7:0];
			if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
				o_hrdata <= (i_haddr[31:8] == 24'h000000) ? rd_val : 32'h00000000;
			end
		end
	end

	// Configuration registers written in the data phase.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			backoff_limit_field_ff <= HWCFG_RST;
			maccr_ff <= MACCR_RST;
			flow_ff  <= FLOW_RST;
		end else if (wpend_ff) begin
			case (waddr_ff)
				REG_HWCFG: backoff_limit_field_ff <= i_hwdata[3:0];
				REG_MACCR: maccr_ff <= i_hwdata[5:0];
				REG_FLOW:  flow_ff  <= {i_hwdata[19], 1'b0, i_hwdata[17:0]};
				default:   backoff_limit_field_ff <= backoff_limit_field_ff;
			endcase
		end
	end

	// Management master: 32 ones, start, opcode, addresses, turnaround, 16 data bits.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			acc_ff      <= 12'h000;
			smi_data_ff <= 16'h0000;
			sh_ff       <= 64'h0;
			bit_ff      <= 6'h00;
			mdiv_ff     <= 5'h00;
			smi_busy_ff <= 1'b0;
			o_mdc       <= 1'b0;
		end else if (!smi_busy_ff) begin
			if (wpend_ff && waddr_ff == REG_SMIDATA) begin
				smi_data_ff <= i_hwdata[15:0];
			end
			if (wpend_ff && waddr_ff == REG_SMIACC && i_hwdata[ACC_BUSY]) begin
				acc_ff      <= i_hwdata[11:0];
				smi_busy_ff <= 1'b1;
				bit_ff      <= 6'h00;
				mdiv_ff     <= 5'(MDC_CYC - 1);
				sh_ff       <= {32'hffffffff, 2'b01, i_hwdata[ACC_WR] ? 2'b01 : 2'b10,
					i_hwdata[ACC_PHY+:5], i_hwdata[ACC_REG+:5], 2'b10, smi_data_ff};
			end
		end else if (mdiv_ff != 5'h00) begin
			mdiv_ff <= mdiv_ff - 5'h01;
		end else begin
			mdiv_ff <= 5'(MDC_CYC - 1);
			o_mdc   <= !o_mdc;
			if (!o_mdc && !acc_ff[ACC_WR] && bit_ff >= 6'(SMI_DATA_BIT)) begin
				smi_data_ff <= {smi_data_ff[14:0], mdio_s};
			end
			if (o_mdc) begin
				sh_ff  <= {sh_ff[62:0], 1'b0};
				bit_ff <= bit_ff + 6'h01;
				if (bit_ff == 6'(SMI_BITS - 1)) begin
					smi_busy_ff <= 1'b0;
				end
			end
		end
	end
	assign o_mdio_out = sh_ff[63];
	assign o_mdio_oe  = smi_busy_ff && (acc_ff[ACC_WR] || bit_ff < 6'(SMI_TA_BIT));
endmodule : gem_mac

// [rtl/gem_pkg.sv]
// Shared constants, types and helper functions of the Ethernet MAC core.
package gem_pkg;
	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] REG_HWCFG   = 8'h00;
	localparam logic [7:0] REG_MACCR   = 8'h04;
	localparam logic [7:0] REG_FLOW    = 8'h08;
	localparam logic [7:0] REG_SMIACC  = 8'h0c;
	localparam logic [7:0] REG_SMIDATA = 8'h10;
	localparam logic [7:0] REG_STAT    = 8'h14;
	// Field positions.
	localparam int CR_FDX = 0, CR_SPD = 1, CR_NORETRY = 3, CR_TXEN = 4, CR_RXEN = 5;
	localparam int FLOW_AUTO = 16, FLOW_RXEN = 17, FLOW_FORCE = 18, FLOW_FWD = 19;
	localparam int ACC_PHY = 0, ACC_REG = 5, ACC_WR = 10, ACC_BUSY = 11;
	localparam int STAT_PAUSED = 16, STAT_TXBUSY = 17, STAT_ATT = 20;
	// Values after reset.
	localparam logic [3:0] HWCFG_RST = 4'ha;
	localparam logic [5:0] MACCR_RST = 6'h31;
	localparam logic [19:0] FLOW_RST = 20'h00000;
	// Speed codes.
	localparam logic [1:0] SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_1000 = 2'h2;
	// Frame geometry in bytes.
	localparam int PRE_BYTES = 8, MIN_FRAME = 60, MIN_NOFCS = 64, SLOT_BYTES = 64;
	localparam int JAM_BYTES = 4, IPG_BYTES = 12, MAX_ATTEMPTS = 16, PAUSE_LEN = 18;
	localparam int MIN_PAYLOAD = 46, HDR_BYTES = 14, FCS_BYTES = 4;
	localparam logic [7:0] PRE_BYTE = 8'h55, SFD_BYTE = 8'hd5, JAM_BYTE = 8'haa;
	localparam logic [31:0] CRC_INIT = 32'hffffffff, CRC_RESIDUE = 32'hdebb20e3;
	// Timing: nibble periods and management clock half period.
	localparam int CLK_NS = 25;
	localparam int NIB_NS_100 = 40, NIB_NS_10 = 400, MDC_HALF_NS = 200;
	localparam int NIB_CYC_100 = (NIB_NS_100 / CLK_NS) < 1 ? 1 : NIB_NS_100 / CLK_NS;
	localparam int NIB_CYC_10 = (NIB_NS_10 / CLK_NS) < 1 ? 1 : NIB_NS_10 / CLK_NS;
	localparam int MDC_CYC = (MDC_HALF_NS / CLK_NS) < 1 ? 1 : MDC_HALF_NS / CLK_NS;
	localparam int SMI_BITS = 64, SMI_TA_BIT = 46, SMI_DATA_BIT = 48;

	typedef enum logic [7:0] {
		TX_IDLE = 8'h01, TX_PRE = 8'h02, TX_DATA = 8'h04, TX_PAD = 8'h08,
		TX_FCS = 8'h10, TX_JAM = 8'h20, TX_BOFF = 8'h40, TX_IPG = 8'h80
	} gem_tx_state_e;
	typedef enum logic [1:0] {RX_IDLE = 2'h1, RX_BODY = 2'h2} gem_rx_state_e;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
		logic       fcs_en;
	} gem_tx_s;
	typedef struct packed {
		logic [7:0] data;
		logic       vld;
		logic       eof;
		logic       err;
		logic       ctl;
	} gem_rx_s;

	// One byte step of the reflected Ethernet CRC-32.
	function automatic logic [31:0] gem_crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
		end
		return r;
	endfunction : gem_crc_byte

	// Byte of a pause frame at a given index; also the reference for receive checks.
	function automatic logic [7:0] gem_pause_byte(input logic [15:0] idx,
			input logic [15:0] qt, input logic [47:0] sa);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			16'd0: r = 8'h01;
			16'd1: r = 8'h80;
			16'd2: r = 8'hc2;
			16'd5: r = 8'h01;
			16'd12: r = 8'h88;
			16'd13: r = 8'h08;
			16'd15: r = 8'h01;
			16'd16: r = qt[15:8];
			16'd17: r = qt[7:0];
			default: begin
				if (idx >= 16'd6 && idx <= 16'd11) begin
					r = 8'(sa >> (6'd8 * (6'd11 - idx[5:0])));
				end
			end
		endcase
		return r;
	endfunction : gem_pause_byte
endpackage : gem_pkg

// [verif/gem_mac_monitor.sv]
// Port checker of the Ethernet MAC core.
`timescale 1ns/1ps
module gem_mac_monitor (
	// Watched ports.
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic i_tx_valid,
	input wire logic o_tx_ready,
	input wire logic o_frame_rewind,
	input wire logic o_frame_release,
	input wire logic o_phy_tx_en,
	input wire logic o_phy_gmii_sel,
	input wire logic o_mdc
);
	logic [7:0] len_ff;
	// Wire length of a frame; it saturates so long frames never wrap small.
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) len_ff <= 8'h00;
		else len_ff <= o_phy_tx_en ? len_ff + 8'(len_ff != 8'hff) : 8'h00;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	property p_bus; o_hreadyout && !o_hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus answer");
	property p_rel; o_frame_release |=> !o_frame_release; endproperty
	a_rel: assert property (p_rel) else $error("release width");
	property p_rew; o_frame_rewind |-> !o_frame_release ##1 !o_frame_rewind; endproperty
	a_rew: assert property (p_rew) else $error("rewind width");
	property p_ipg; $fell(o_phy_tx_en) |-> !o_phy_tx_en [*8]; endproperty
	a_ipg: assert property (p_ipg) else $error("gap short");
	property p_pad; $fell(o_phy_tx_en) && o_phy_gmii_sel |-> len_ff >= 8'h48; endproperty
	a_pad: assert property (p_pad) else $error("frame short");
	property p_take; o_tx_ready |-> i_tx_valid; endproperty
	a_take: assert property (p_take) else $error("take without data");
	property p_lane; o_phy_tx_en && $past(o_phy_tx_en) |-> $stable(o_phy_gmii_sel); endproperty
	a_lane: assert property (p_lane) else $error("lane change");
	property p_mdc; $rose(o_mdc) |-> o_mdc [*8] ##1 !o_mdc; endproperty
	a_mdc: assert property (p_mdc) else $error("mdc period");
	c_rew: cover property (o_frame_rewind);
	c_rel: cover property (o_frame_release);
	c_mdc: cover property ($rose(o_mdc));
endmodule : gem_mac_monitor

bind gem_mac gem_mac_monitor gem_mac_monitor_inst (.i_core_clk, .i_rstn, .o_hreadyout,
	.o_hresp, .i_tx_valid, .o_tx_ready, .o_frame_rewind, .o_frame_release, .o_phy_tx_en,
	.o_phy_gmii_sel, .o_mdc);

// [verif/gem_phy_model.sv]
// Loopback PHY stand-in with forced collisions and a pulled-up management line.
`timescale 1ns/1ps
module gem_phy_model (
	// MAC side.
	input  wire logic       i_clk,
	input  wire logic       i_col_req,
	input  wire logic [7:0] i_txd,
	input  wire logic       i_tx_en,
	input  wire logic       i_mdio_out,
	input  wire logic       i_mdio_oe,
	output logic      [7:0] o_rxd,
	output logic            o_rx_dv,
	output logic            o_col,
	output logic            o_mdio_in
);
	int n_byte;
	// Echo the wire; idle lanes show the inverse so stale data cannot pass.
	always @(posedge i_clk) begin
		o_rxd <= i_tx_en ? i_txd : ~i_txd;
		o_rx_dv <= i_tx_en;
		o_col <= i_col_req & i_tx_en;
		n_byte <= n_byte + int'(i_tx_en);
	end
	// A released management line floats high on its pull-up.
	assign o_mdio_in = i_mdio_oe ? i_mdio_out : 1'b1;
endmodule : gem_phy_model

// [verif/gem_mac_tb.sv]
// Bench of the MAC core: registers, frames, pause and collisions.
`timescale 1ns/1ps
module gem_mac_tb import gem_pkg::*;;
	logic i_core_clk, i_rstn, i_hsel, i_hwrite, i_hready, i_tx_valid, i_flow_on, i_flow_off;
	logic i_phy_rx_dv, i_phy_rx_er, i_phy_col, i_phy_crs, i_mdio_in, o_hreadyout, o_hresp;
	logic o_tx_ready, o_frame_rewind, o_frame_release, o_phy_tx_en, o_phy_gmii_sel;
	logic o_mdc, o_mdio_out, o_mdio_oe, fcs, col_req, rx_err;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize;
	logic [7:0] o_phy_txd, i_phy_rxd;
	logic [31:0] i_haddr, i_hwdata, o_hrdata, q;
	gem_tx_s i_tx;
	gem_rx_s o_rx;
	int fail_count, samples_checked, n_rew, n_rel, n_rx, n_eof, idx, len, b0, x0, y0, r0, w0;
	gem_mac gem_mac_inst (.*);
	gem_phy_model gem_phy_model_inst (.i_clk(i_core_clk), .i_col_req(col_req),
		.i_txd(o_phy_txd), .i_tx_en(o_phy_tx_en), .i_mdio_out(o_mdio_out),
		.i_mdio_oe(o_mdio_oe), .o_rxd(i_phy_rxd), .o_rx_dv(i_phy_rx_dv), .o_col(i_phy_col),
		.o_mdio_in(i_mdio_in));
	assign i_hready = o_hreadyout;
	assign i_phy_crs = i_phy_col;
	assign i_tx = '{8'(idx), idx == len - 1, fcs};
	// Free-running core clock.
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end
	// FIFO controller stand-in: a rewind restarts the frame, a release retires it.
	always @(posedge i_core_clk) begin
		n_rew <= n_rew + int'(o_frame_rewind);
		n_rel <= n_rel + int'(o_frame_release);
		n_rx <= n_rx + int'(o_rx.vld);
		n_eof <= n_eof + int'(o_rx.eof);
		if (o_rx.eof) rx_err <= o_rx.err;
		if (o_frame_rewind || o_frame_release) idx <= 0;
		else if (o_tx_ready) idx <= idx + 1;
		if (o_frame_release) i_tx_valid <= 1'b0;
	end
	task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		i_htrans <= 2'h2;
		i_hwrite <= wr;
		i_haddr <= {24'h0, a};
		do @(posedge i_core_clk); while (!i_hready);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_core_clk); while (!i_hready);
		q = o_hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m = 32'hffffffff);
		bus(1'b0, a, 32'h0);
		check("register", e, q & m);
	endtask : rd
	task automatic mark();
		b0 = gem_phy_model_inst.n_byte;
		x0 = n_eof;
		y0 = n_rx;
		r0 = n_rel;
		w0 = n_rew;
	endtask : mark
	task automatic await(input int wb, input int rb, input logic e);
		for (int t = 0; t < 400 && n_eof == x0; t++) @(posedge i_core_clk);
		check("wire bytes", wb, gem_phy_model_inst.n_byte - b0);
		if (rb >= 0) check("rx bytes", rb, n_rx - y0);
		if (rb >= 0) check("rx error", {31'h0, e}, {31'h0, rx_err});
	endtask : await
	task automatic frame(input int n, input logic f, input int wb, input int rb, input logic e);
		mark();
		len <= n;
		fcs <= f;
		i_tx_valid <= 1'b1;
		for (int t = 0; t < 20000 && n_rel == r0; t++) @(posedge i_core_clk);
		if (wb >= 0) await(wb, rb, e);
	endtask : frame
	task automatic conclude();
		if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	// Watchdog sized well above the expected run of some four thousand cycles.
	initial begin
		#1500000;
		fail_count++;
		conclude();
	end
	// Main sequence.
	initial begin
		{i_rstn, i_hwrite, i_tx_valid, i_flow_on, i_flow_off, fcs, col_req, i_phy_rx_er} = '0;
		{i_htrans, i_haddr, i_hwdata, len} = '0;
		i_hsel = 1'b1;
		i_hsize = 3'h2;
		repeat (6) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		rd(REG_HWCFG, 32'h0000000a);
		rd(REG_MACCR, 32'h00000031);
		rd(REG_FLOW, 32'h00000000);
		bus(1'b1, 8'h18, 32'hffffffff);
		rd(8'h18, 32'h00000000);
		bus(1'b1, REG_HWCFG, 32'h00000001);
		rd(REG_HWCFG, 32'h00000001);
		bus(1'b1, REG_SMIACC, 32'h00000841);
		q[ACC_BUSY] = 1'b1;
		for (int t = 0; t < 2000 && q[ACC_BUSY] !== 1'b0; t++) bus(1'b0, REG_SMIACC, 32'h0);
		rd(REG_SMIDATA, 32'h0000ffff, 32'h0000ffff);
		bus(1'b1, REG_MACCR, 32'h00000035);
		frame(10, 1'b1, 72, 14, 1'b0);
		frame(70, 1'b0, 78, 66, 1'b1);
		frame(70, 1'b1, 82, 70, 1'b0);
		mark();
		bus(1'b1, REG_FLOW, 32'h00060002);
		await(72, -1, 1'b1);
		rd(REG_STAT, 32'h00010000, 32'h00010000);
		check("pause release", 0, n_rel - r0);
		bus(1'b1, REG_FLOW, 32'h00010005);
		for (int k = 0; k < 3; k++) begin
			mark();
			i_flow_on <= k < 2;
			i_flow_off <= k == 2;
			@(posedge i_core_clk);
			{i_flow_on, i_flow_off} <= 2'h0;
			await(k == 1 ? 0 : 72, -1, 1'b0);
		end
		col_req <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, REG_MACCR, k == 0 ? 32'h00000032 : k == 1 ? 32'h0000003a : 32'h00000033);
			frame(10, 1'b1, -1, -1, 1'b0);
			check("rewinds", k == 0 ? 15 : 0, n_rew - w0);
			check("releases", 1, n_rel - r0);
		end
		conclude();
	end
endmodule : gem_mac_tb
